// ===== hw/ccc_pkg.sv
// ============================================================================
// Shared constants for the core control front-end
// ============================================================================
package ccc_pkg;

    // ========================================================================
    // Register map, byte addresses on the APB
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_RETIRED = 12'h008;
    localparam logic [11:0] ADDR_STALLS  = 12'h00C;

    // ========================================================================
    // Control register fields
    localparam int          CTRL_W        = 5;
    localparam int          CTRL_BIG_BIT  = 0;   // Byte order, 1 = big-endian
    localparam int          CTRL_BYP_BIT  = 1;   // Interrupt synchroniser bypass
    localparam int          CTRL_PRED_BIT = 2;   // Branch prediction enable
    localparam int          CTRL_FDIS_BIT = 3;   // Fast interrupt disable
    localparam int          CTRL_IDIS_BIT = 4;   // Normal interrupt disable
    // Both interrupts come out of reset disabled, little-endian, no prediction
    localparam logic [4:0]  CTRL_RST      = 5'h18;

    // ========================================================================
    // Core timing figures
    localparam int          PIPE_STAGES   = 5;
    localparam int          OPERAND_W     = 32;
    localparam int          MUL_BITS_CYC  = 8;
    localparam int          MAX_FREE_LSL  = 3;
    localparam int          BASE_CYC      = 1;
    localparam int          MUL_CYC       = OPERAND_W / MUL_BITS_CYC;
    localparam logic [31:0] RESTART_ADDR  = 32'h0000_0000;

    // ========================================================================
    // Core state, one-hot
    typedef enum logic [3:0] {
        ST_HALT    = 4'h1,
        ST_RESTART = 4'h2,
        ST_IDLE    = 4'h4,
        ST_BUSY    = 4'h8
    } ccc_state_t;

    // Instruction classes presented by the decode stage
    typedef enum logic [2:0] {
        K_ALU       = 3'h0,
        K_SHIFT_ADD = 3'h1,
        K_LOAD      = 3'h2,
        K_STORE     = 3'h3,
        K_MUL       = 3'h4,
        K_COP_REG   = 3'h5,
        K_COP_MEM   = 3'h6,
        K_BRANCH    = 3'h7
    } ccc_kind_t;

endpackage

// ===== hw/ccc_irq_if.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Interrupt path between the control core and its synchroniser
// ============================================================================
interface ccc_irq_if;
    logic fast_n;
    logic normal_n;
    logic bypass;
    logic clk_en;
    logic fast_req;
    logic normal_req;

    modport core (output fast_n, normal_n, bypass, clk_en, input fast_req, normal_req);
    modport sync (input fast_n, normal_n, bypass, clk_en, output fast_req, normal_req);
endinterface
`default_nettype wire

// ===== hw/ccc_irq_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Two-flop interrupt synchroniser with bypass
// ============================================================================
module ccc_irq_sync
(
    // Clock and reset
    input  wire logic  mclk_i,
    input  wire logic  reset_i,
    // Interrupt path
    ccc_irq_if.sync    irq
);

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stab;
    } ccc_sync_st_t;

    ccc_sync_st_t s_r;
    ccc_sync_st_t s_nxt;
    logic [1:0]   raw;
    logic [1:0]   req;

    // Active-high requests, bit 0 fast and bit 1 normal
    assign raw = ~{irq.normal_n, irq.fast_n};

    // Stages only move on enabled cycles, so a held core keeps its history
    always_comb
    begin
        s_nxt = s_r;
        if (irq.clk_en)
        begin
            s_nxt.meta = raw;
            s_nxt.stab = s_r.meta;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // Per-channel choice between synchronised and direct sampling
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_sel
            assign req[g] = irq.bypass ? raw[g] : s_r.stab[g];
        end
    endgenerate

    assign irq.fast_req   = req[0];
    assign irq.normal_req = req[1];

    // ========================================================================
    // Checks
    chk_sync_two_flop: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (!irq.bypass && irq.clk_en) [*3] |-> irq.fast_req == !$past(irq.fast_n, 2))
        else $error("fast request does not trail the pin by two flops");

    chk_sync_bypass: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        irq.bypass |-> irq.normal_req == !irq.normal_n)
        else $error("bypassed normal request differs from pin");

endmodule
`default_nettype wire

// ===== hw/ccc_core_ctrl.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Notes on behaviour
// - Each clock period is a low phase then a high phase.
// - One clock drives core, prefetch unit and coprocessors.
// - Hold low lets the core advance every cycle.
// - Byte order select high means big-endian, low little-endian.
// - Fast interrupt taken only while its status enable is active.
// - Normal interrupt gated by own enable, loses to fast.
// - Prediction on folds branches; off passes every branch to core.
// - After reset goes high, fetch restarts at address zero; the core waits for two high cycles.
// - Five-stage pipeline, four of them data stages.
// - Word load followed by a consumer costs one extra cycle.
// - Shift plus add costs one cycle, except left shift up to three.
// - Single loads and stores take one cycle.
// - Multiplier retires eight multiplier bits per cycle.
// - Coprocessor register transfers only; memory transfers are refused.
// ============================================================================
module ccc_core_ctrl
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // System pins
    input  wire logic        clock_hold_request_i,
    input  wire logic        core_reset_n_i,
    input  wire logic        fast_irq_n_i,
    input  wire logic        normal_irq_n_i,
    // Instruction issue from decode
    input  wire logic        instr_valid_i,
    input  wire logic [2:0]  instr_kind_i,
    input  wire logic        instr_uses_load_i,
    input  wire logic        instr_shift_left_i,
    input  wire logic [4:0]  instr_shift_amt_i,
    input  wire logic [31:0] mem_rdata_i,
    output logic             instr_ready_o,
    // Core status and events
    output logic             core_clk_en_o,
    output logic             instr_done_o,
    output logic      [2:0]  instr_cycles_o,
    output logic             instr_abort_o,
    output logic             instr_undef_o,
    output logic             branch_folded_o,
    output logic             fetch_restart_o,
    output logic      [31:0] fetch_addr_o,
    output logic             fiq_take_o,
    output logic             irq_take_o,
    output logic      [31:0] load_data_o,
    output logic             byte_order_o,
    output logic             predict_enable_o
);

    typedef struct packed {
        ccc_pkg::ccc_state_t state;
        logic [2:0]          cnt;
        logic                last_load;
        logic [4:0]          stages;
        logic [4:0]          ctrl;
        logic [31:0]         retired;
        logic [31:0]         stalls;
        logic                done;
        logic                abort;
        logic                restart;
        logic                fold;
        logic                undef;
        logic                fiq_take;
        logic                irq_take;
        logic [2:0]          cycles;
        logic [31:0]         fetch_addr;
        logic [31:0]         load_data;
        logic [31:0]         prdata;
        logic                pslverr;
    } ccc_core_st_t;

    ccc_core_st_t s_r;
    ccc_core_st_t s_nxt;
    logic         clk_en;
    logic         fiq_want;
    logic         irq_want;
    logic         accept;
    logic         apb_wr;

    ccc_irq_if    irq_bus ();

    // ========================================================================
    // Byte lane reversal for big-endian loads
    function automatic logic [31:0] swap_bytes(input logic [31:0] w);
        swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // ========================================================================
    // Internal clock is this clock gated by the hold request; one clock only,
    // the hold becomes an enable so no gated clock tree is needed
    assign clk_en        = !clock_hold_request_i;
    assign core_clk_en_o = clk_en;

    // Interrupt synchroniser
    assign irq_bus.fast_n   = fast_irq_n_i;
    assign irq_bus.normal_n = normal_irq_n_i;
    assign irq_bus.bypass   = s_r.ctrl[ccc_pkg::CTRL_BYP_BIT];
    assign irq_bus.clk_en   = clk_en;

    ccc_irq_sync u_irq_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .irq     (irq_bus)
    );

    // Interrupt priority: fast wins over normal in the same cycle
    assign fiq_want = irq_bus.fast_req && !s_r.ctrl[ccc_pkg::CTRL_FDIS_BIT];
    assign irq_want = irq_bus.normal_req && !s_r.ctrl[ccc_pkg::CTRL_IDIS_BIT]
                      && !fiq_want;

    // Issue handshake; interrupts are taken between instructions
    assign instr_ready_o = (s_r.state == ccc_pkg::ST_IDLE) && clk_en && core_reset_n_i
                           && !fiq_want && !irq_want;
    assign accept        = instr_ready_o && instr_valid_i;
    assign apb_wr        = psel_i && penable_i && pwrite_i;

    // Zero wait states: every access completes in its first access cycle
    assign pready_o = 1'b1;

    // ========================================================================
    // Next-state logic
    always_comb
    begin
        logic [2:0] cyc;
        cyc = 3'(ccc_pkg::BASE_CYC);
        s_nxt          = s_r;
        s_nxt.done     = 1'b0;
        s_nxt.abort    = 1'b0;
        s_nxt.restart  = 1'b0;
        s_nxt.fold     = 1'b0;
        s_nxt.undef    = 1'b0;
        s_nxt.fiq_take = 1'b0;
        s_nxt.irq_take = 1'b0;

        // Read data and error are prepared in the setup cycle
        if (psel_i && !penable_i)
        begin
            s_nxt.pslverr = 1'b0;
            unique case (paddr_i)
                ccc_pkg::ADDR_CTRL:    s_nxt.prdata = {27'h000_0000, s_r.ctrl};
                ccc_pkg::ADDR_STATUS:  s_nxt.prdata = {18'h0_0000, irq_bus.normal_req,
                                                       irq_bus.fast_req, s_r.stages,
                                                       s_r.state, s_r.cycles};
                ccc_pkg::ADDR_RETIRED: s_nxt.prdata = s_r.retired;
                ccc_pkg::ADDR_STALLS:  s_nxt.prdata = s_r.stalls;
                default:
                begin
                    s_nxt.prdata  = 32'h0000_0000;
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // Software write first, so hardware sets below win the same cycle
        if (apb_wr && paddr_i == ccc_pkg::ADDR_CTRL && pstrb_i[0])
            s_nxt.ctrl = pwdata_i[4:0];

        // Cycle cost of the offered instruction
        unique case (ccc_pkg::ccc_kind_t'(instr_kind_i))
            ccc_pkg::K_SHIFT_ADD:
                if (!(instr_shift_left_i && instr_shift_amt_i <= 5'(ccc_pkg::MAX_FREE_LSL)))
                    cyc = 3'(ccc_pkg::BASE_CYC + 1);
            ccc_pkg::K_MUL:
                cyc = 3'(ccc_pkg::MUL_CYC);
            default:
                cyc = 3'(ccc_pkg::BASE_CYC);
        endcase
        if (s_r.last_load && instr_uses_load_i)
            cyc = cyc + 3'h1;

        if (!core_reset_n_i)
        begin
            // Reset cuts off whatever is in flight, hold or no hold
            if (s_r.state == ccc_pkg::ST_BUSY)
                s_nxt.abort = 1'b1;
            s_nxt.state     = ccc_pkg::ST_HALT;
            s_nxt.cnt       = 3'h0;
            s_nxt.stages    = 5'h00;
            s_nxt.last_load = 1'b0;
        end
        else if (clk_en)
        begin
            // Issue slot enters stage one and walks through all five
            s_nxt.stages = {s_r.stages[3:0], accept};
            unique case (s_r.state)
                ccc_pkg::ST_HALT:
                    s_nxt.state = ccc_pkg::ST_RESTART;
                ccc_pkg::ST_RESTART:
                begin
                    s_nxt.restart    = 1'b1;
                    s_nxt.fetch_addr = ccc_pkg::RESTART_ADDR;
                    s_nxt.state      = ccc_pkg::ST_IDLE;
                end
                ccc_pkg::ST_IDLE:
                begin
                    if (fiq_want)
                    begin
                        // Entering the fast handler masks both sources
                        s_nxt.fiq_take                      = 1'b1;
                        s_nxt.ctrl[ccc_pkg::CTRL_FDIS_BIT]  = 1'b1;
                        s_nxt.ctrl[ccc_pkg::CTRL_IDIS_BIT]  = 1'b1;
                        s_nxt.last_load                     = 1'b0;
                    end
                    else if (irq_want)
                    begin
                        s_nxt.irq_take                      = 1'b1;
                        s_nxt.ctrl[ccc_pkg::CTRL_IDIS_BIT]  = 1'b1;
                        s_nxt.last_load                     = 1'b0;
                    end
                    else if (accept)
                    begin
                        s_nxt.last_load = (instr_kind_i == ccc_pkg::K_LOAD);
                        s_nxt.cycles    = cyc;
                        if (instr_kind_i == ccc_pkg::K_COP_MEM)
                        begin
                            s_nxt.undef  = 1'b1;
                            s_nxt.cycles = 3'h0;
                        end
                        else if (instr_kind_i == ccc_pkg::K_BRANCH
                                 && s_r.ctrl[ccc_pkg::CTRL_PRED_BIT])
                        begin
                            // Folded in the prefetch unit, costs no core cycle
                            s_nxt.fold    = 1'b1;
                            s_nxt.cycles  = 3'h0;
                            s_nxt.retired = s_r.retired + 32'h0000_0001;
                        end
                        else
                        begin
                            s_nxt.cnt   = cyc;
                            s_nxt.state = ccc_pkg::ST_BUSY;
                        end
                        if (instr_kind_i == ccc_pkg::K_LOAD)
                            s_nxt.load_data = s_r.ctrl[ccc_pkg::CTRL_BIG_BIT]
                                              ? swap_bytes(mem_rdata_i)
                                              : mem_rdata_i;
                    end
                end
                ccc_pkg::ST_BUSY:
                begin
                    s_nxt.cnt = s_r.cnt - 3'h1;
                    if (s_r.cnt == 3'h1)
                    begin
                        s_nxt.done    = 1'b1;
                        s_nxt.state   = ccc_pkg::ST_IDLE;
                        s_nxt.retired = s_r.retired + 32'h0000_0001;
                    end
                end
            endcase
        end
        else if (s_r.state != ccc_pkg::ST_HALT)
            s_nxt.stalls = s_r.stalls + 32'h0000_0001;
    end

    // ========================================================================
    // State register
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_r            <= '0;
            s_r.state      <= ccc_pkg::ST_HALT;
            s_r.ctrl       <= ccc_pkg::CTRL_RST;
            s_r.fetch_addr <= ccc_pkg::RESTART_ADDR;
        end
        else
            s_r <= s_nxt;
    end

    // ========================================================================
    // Outputs
    assign prdata_o         = s_r.prdata;
    assign pslverr_o        = s_r.pslverr;
    assign instr_done_o     = s_r.done;
    assign instr_cycles_o   = s_r.cycles;
    assign instr_abort_o    = s_r.abort;
    assign instr_undef_o    = s_r.undef;
    assign branch_folded_o  = s_r.fold;
    assign fetch_restart_o  = s_r.restart;
    assign fetch_addr_o     = s_r.fetch_addr;
    assign fiq_take_o       = s_r.fiq_take;
    assign irq_take_o       = s_r.irq_take;
    assign load_data_o      = s_r.load_data;
    assign byte_order_o     = s_r.ctrl[ccc_pkg::CTRL_BIG_BIT];
    assign predict_enable_o = s_r.ctrl[ccc_pkg::CTRL_PRED_BIT];

    // ========================================================================
    // Checks
    chk_hold_freeze: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (clock_hold_request_i && core_reset_n_i) |=> $stable(s_r.state) && $stable(s_r.cnt))
        else $error("core state moved while held");

    chk_hold_follow: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (s_r.state == ccc_pkg::ST_BUSY && s_r.cnt == 3'h1 && !clock_hold_request_i
         && core_reset_n_i) |=> instr_done_o && s_r.state == ccc_pkg::ST_IDLE)
        else $error("unheld core did not advance");

    chk_fiq_gate: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        fiq_take_o |-> $past(irq_bus.fast_req) && !$past(s_r.ctrl[ccc_pkg::CTRL_FDIS_BIT]))
        else $error("fast interrupt taken while disabled or absent");

    chk_fiq_priority: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        irq_take_o |-> !$past(fiq_want) && !fiq_take_o)
        else $error("normal interrupt beat a fast one");

    chk_predict_fold: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (accept && instr_kind_i == ccc_pkg::K_BRANCH)
        |=> branch_folded_o == $past(s_r.ctrl[ccc_pkg::CTRL_PRED_BIT]))
        else $error("branch folding does not follow prediction enable");

    chk_reset_abort: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (!core_reset_n_i && s_r.state == ccc_pkg::ST_BUSY) |=> instr_abort_o)
        else $error("core reset did not abort the instruction");

    chk_restart_zero: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        fetch_restart_o |-> fetch_addr_o == ccc_pkg::RESTART_ADDR
                            && $past(core_reset_n_i) && $past(core_reset_n_i, 2))
        else $error("restart without a high reset cycle or off zero");

    chk_load_interlock: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (accept && s_r.last_load && instr_uses_load_i && instr_kind_i == ccc_pkg::K_ALU)
        |=> instr_cycles_o == 3'h2)
        else $error("load-use interlock not two cycles");

    chk_shift_add: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (accept && !s_r.last_load && instr_kind_i == ccc_pkg::K_SHIFT_ADD
         && instr_shift_left_i && instr_shift_amt_i == 5'h04) |=> instr_cycles_o == 3'h2)
        else $error("shift then add did not cost a cycle");

    chk_mul_rate: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (accept && !s_r.last_load && instr_kind_i == ccc_pkg::K_MUL)
        |=> (instr_cycles_o == 3'h4
             and ((!clock_hold_request_i && core_reset_n_i) [*4] |=> instr_done_o)))
        else $error("multiply not eight bits per cycle");

    chk_cop_reject: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (accept && instr_kind_i == ccc_pkg::K_COP_MEM)
        |=> instr_undef_o && s_r.state == ccc_pkg::ST_IDLE)
        else $error("coprocessor memory transfer accepted");

endmodule
`default_nettype wire

// ===== test/ccc_sys_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// System side: reset source and interrupt sources
module ccc_sys_model
(
    // Clock and requests from the bench, fast interrupt in bit 1
    input  wire logic       mclk_i,
    input  wire logic       rst_req_i,
    input  wire logic [1:0] irq_req_i,
    // Takes from the core
    input  wire logic [1:0] take_i,
    // System pins
    output logic            core_reset_n_o,
    output logic      [1:0] irq_n_o
);
    logic [1:0] cnt_r = 2'h2;
    logic [1:0] req_r = 2'h0;
    // A one-cycle request still gives a two-cycle reset; levels hold until taken
    always @(posedge mclk_i)
    begin
        cnt_r <= rst_req_i ? 2'h2 : cnt_r - {1'b0, cnt_r != 2'h0};
        req_r <= irq_req_i | (req_r & ~take_i);
    end
    // Pins only move just after an edge
    assign core_reset_n_o = (cnt_r == 2'h0);
    assign irq_n_o        = ~req_r;
endmodule
`default_nettype wire

// ===== test/core_control_and_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Bench for the core control front-end
module core_control_and_config_tb;
    logic mclk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, hold = 0, vld = 0, use_l = 0, e;
    logic rreq = 0, big = 0, pred = 0, prev_ld = 0, rstn, pready, pslverr, irdy, clken, done;
    logic abrt, undef, fold, frst, fiq_t, irq_t, bo, pe;
    logic [1:0] irq_req = 0, irqn;
    logic [2:0] knd = 0, cyc_o;
    logic [5:0] shf = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, md = 0, q, prdata, faddr, ld;
    integer fails = 0, check_count = 0, seed = 32'h51be, cyc = 0, w = 0, ret = 0;
    // Device and its system side
    ccc_core_ctrl i_dut (.mclk_i(mclk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hf), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .clock_hold_request_i(hold),
        .core_reset_n_i(rstn), .fast_irq_n_i(irqn[1]), .normal_irq_n_i(irqn[0]),
        .instr_valid_i(vld), .instr_kind_i(knd), .instr_uses_load_i(use_l),
        .instr_shift_left_i(shf[5]), .instr_shift_amt_i(shf[4:0]), .mem_rdata_i(md),
        .instr_ready_o(irdy), .core_clk_en_o(clken), .instr_done_o(done),
        .instr_cycles_o(cyc_o), .instr_abort_o(abrt), .instr_undef_o(undef),
        .branch_folded_o(fold), .fetch_restart_o(frst), .fetch_addr_o(faddr),
        .fiq_take_o(fiq_t), .irq_take_o(irq_t), .load_data_o(ld), .byte_order_o(bo),
        .predict_enable_o(pe));
    ccc_sys_model i_sys (.mclk_i(mclk), .rst_req_i(rreq), .irq_req_i(irq_req),
        .take_i({fiq_t, irq_t}), .core_reset_n_o(rstn), .irq_n_o(irqn));
    // Clock, and a watchdog so a lost handshake cannot hang the run
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 20000) begin fails++; final_report; end
    task automatic final_report;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin fails++; $display("unexpected %s exp %h got %h", nm, x, g); end
    endtask
    // APB cycle: setup, then access held until pready at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
        @(posedge mclk);
        pen <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        {q, e} = {prdata, pslverr};
        {psel, pen} <= 2'b00;
    endtask
    function automatic logic [2:0] cost(input logic [2:0] k, input logic lu, input logic [5:0] s);
        cost = ((k == 3'h4) ? 3'h4 : 3'h1) + {2'h0, lu};
        if (k == 3'h1 && !(s[5] && s[4:0] <= 5'h03)) cost = cost + 3'h1;
    endfunction
    // Called just after an edge; optionally expects the running instruction to abort
    task automatic core_rst(input logic ab);
        rreq <= 1'b1;
        @(posedge mclk);
        rreq <= 1'b0;
        repeat (9) if (ab && abrt !== 1'b1) @(negedge mclk);
        if (ab) chk("abort", 1, abrt);
        repeat (20) if (frst !== 1'b1) @(negedge mclk);
        chk("restart", 1, frst);
        chk("fetch address", 0, faddr);
    endtask
    // Offer one instruction, then follow it under random hold
    task automatic issue(input logic [2:0] k, input logic u, input logic [31:0] m, input logic ab);
        integer n;
        logic [2:0] c;
        c = cost(k, u & prev_ld, m[5:0]);
        @(posedge mclk);
        {vld, knd, use_l, shf, md} <= {1'b1, k, u, m[5:0], m};
        @(negedge mclk);
        while (irdy !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        vld <= 1'b0;
        n = 0;
        prev_ld = (k == 3'h2);
        if (ab) begin core_rst(1'b1); return; end
        ret += int'(k != 3'h6);
        @(negedge mclk);
        if (k == 3'h6 || (k == 3'h7 && pred))
            begin chk("side pulse", 1, k[0] ? fold : undef); return; end
        chk("cycles", c, cyc_o);
        if (k == 3'h2)
            chk("load data", big ? {m[7:0], m[15:8], m[23:16], m[31:24]} : m, ld);
        while (done !== 1'b1 && n < 9)
        begin
            chk("clock enable", !hold, clken);
            n += int'(!hold);
            @(posedge mclk);
            hold <= 1'($random(seed));
            @(negedge mclk);
        end
        chk("done cycle", c, n);
        @(posedge mclk);
        hold <= 1'b0;
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        core_rst(1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h18, q);
        apb(1'b1, 12'h000, 32'h2);
        irq_req <= 2'b11;
        @(posedge mclk) irq_req <= 2'b00;
        repeat (9) if (fiq_t !== 1'b1) @(negedge mclk);
        chk("takes", 32'h2, {30'h0, fiq_t, irq_t});
        apb(1'b1, 12'h000, 32'ha);
        repeat (9) if (irq_t !== 1'b1) @(negedge mclk);
        chk("normal take", 32'h1, {31'h0, irq_t});
        for (int i = 0; i < 48; i++)
        begin
            if (i % 12 == 0) {big, pred} = 2'(i / 12);
            if (i % 12 == 0)
            begin
                apb(1'b1, 12'h000, {29'h3, pred, 1'b0, big});
                @(negedge mclk);
                chk("config pins", {30'h0, pred, big}, {30'h0, pe, bo});
            end
            issue((i % 12 == 1) ? 3'h2 : (i % 12 == 2) ? 3'(i / 12)
                : (i % 12 inside {3, 4}) ? 3'h1 : 3'(i), i % 12 == 2,
                (i % 12 inside {3, 4}) ? 32'h20 + 32'(i % 12) : $random(seed), 1'b0);
        end
        apb(1'b0, 12'h008, 32'h0);
        chk("retired", ret, q);
        // Synchronised path: two flops, the decision edge, then the half-cycle look
        apb(1'b1, 12'h000, 32'h10);
        irq_req <= 2'b10;
        @(posedge mclk) irq_req <= 2'b00;
        while (fiq_t !== 1'b1 && w < 9) begin w++; @(negedge mclk); end
        chk("synchronised take", 4, w);
        issue(3'h4, 1'b0, 32'h0, 1'b1);
        final_report;
    end
endmodule
`default_nettype wire
